// ### hdl/sdi_defs.svh
`ifndef SDI_DEFS_SVH
`define SDI_DEFS_SVH

// ****************************************
// Command codes
// ****************************************
`define SDI_CMD_PROBE 16'h8E00
`define SDI_CMD_SETUP 16'h8E01

// ****************************************
// Result codes
// ****************************************
`define SDI_RES_SUCCESS 8'h00
`define SDI_RES_IO_FAULT 8'h01
`define SDI_RES_NOT_FOUND 8'h02
`define SDI_RES_LOCK_BUSY 8'h03
`define SDI_RES_STATE_DENIED 8'h04
`define SDI_RES_ALREADY_DONE 8'h05
`define SDI_RES_UNSUPPORTED 8'h06
`define SDI_RES_BAD_COMMAND 8'h07

// ****************************************
// Response byte offsets
// ****************************************
`define SDI_OFS_ADDR 2'h0
`define SDI_OFS_REV 2'h1
`define SDI_OFS_MODEL_HI 2'h2
`define SDI_OFS_MODEL_LO 2'h3

// ****************************************
// Timing
// ****************************************
`define SDI_SNS_RESET_NS 20
`define SDI_CLK_PERIOD_NS 5
`define SDI_SNS_RESET_CYC 8'((`SDI_SNS_RESET_NS + `SDI_CLK_PERIOD_NS - 1) / `SDI_CLK_PERIOD_NS)

`endif

// ### hdl/sdi_pkg.sv
`include "sdi_defs.svh"

package sdi_pkg;

  typedef enum logic [7:0]
  {
    RESULT_SUCCESS = `SDI_RES_SUCCESS,
    RESULT_IO_FAULT = `SDI_RES_IO_FAULT,
    RESULT_NOT_FOUND = `SDI_RES_NOT_FOUND,
    RESULT_LOCK_BUSY = `SDI_RES_LOCK_BUSY,
    RESULT_STATE_DENIED = `SDI_RES_STATE_DENIED,
    RESULT_ALREADY_DONE = `SDI_RES_ALREADY_DONE,
    RESULT_UNSUPPORTED_IMAGER = `SDI_RES_UNSUPPORTED,
    RESULT_BAD_COMMAND = `SDI_RES_BAD_COMMAND
  } sdi_result_t;

  typedef enum logic [1:0]
  {
    SYS_IDLE = 2'b00,
    SYS_SUSPENDED = 2'b01,
    SYS_STREAMING = 2'b10,
    SYS_OTHER = 2'b11
  } sdi_sys_state_t;

  typedef enum logic [1:0]
  {
    PROBE_FOUND = 2'b00,
    PROBE_IO_FAULT = 2'b01,
    PROBE_NONE = 2'b10
  } sdi_probe_t;

endpackage

// ### hdl/sdi_if.sv
`timescale 1ns/1ps

interface sdi_if;
  logic cmd_valid;
  logic [15:0] cmd_code;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_status;
  logic rsp_byte_valid;
  logic [7:0] rsp_byte;
  logic serial_bus_manager_lock;

  modport dev
  (
    input cmd_valid,
    input cmd_code,
    input serial_bus_manager_lock,
    output cmd_ready,
    output rsp_valid,
    output rsp_status,
    output rsp_byte_valid,
    output rsp_byte
  );

  modport host
  (
    output cmd_valid,
    output cmd_code,
    output serial_bus_manager_lock,
    input cmd_ready,
    input rsp_valid,
    input rsp_status,
    input rsp_byte_valid,
    input rsp_byte
  );
endinterface

// ### hdl/sdi_device.sv
`timescale 1ns/1ps
`include "sdi_defs.svh"

// Functional notes
// R1: Accept probe command 0x8E00, no parameters.
// R2: Accept setup command 0x8E01, no parameters.
// R3: Auto probe and setup on first config.
// R4: Unrecognized imager rejects the config change.
// R5: Host may probe then patch before config.
// R6: Success returns address, revision, 16-bit model.
// R7: Probe reports success, I/O fault, not-found.
// R8: Reset imager before probing.
// R9: Lock held by host gives busy result.
// R10: Probe only when idle or suspended.
// R11: Setup only when idle or suspended.
// R12: Probe allowed once per reset.
// R13: Setup allowed once per reset.
// R14: Setup applies every stored default record.
// R15: Setup without imager or probe: not-found.
// R16: Unsupported imager gives unsupported result.
// R17: Host may trigger setup manually anytime permitted.
// R18: Multi-byte values sent most significant first.
// R19: One result per command; data only on success.
module sdi_device
  import sdi_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  sdi_if.dev LINK,
  input wire sdi_pkg::sdi_sys_state_t SYS_STATE,
  input wire logic CFG_REQ,
  output logic CFG_DONE,
  output logic CFG_OK,
  output logic SNS_RESET,
  output logic PRB_START,
  input wire logic PRB_DONE,
  input wire sdi_pkg::sdi_probe_t PRB_RESULT,
  input wire logic [7:0] PRB_ADDR,
  input wire logic [7:0] PRB_REV,
  input wire logic [15:0] PRB_MODEL,
  input wire logic SNS_SUPPORTED,
  input wire logic [7:0] REC_COUNT,
  output logic REC_APPLY,
  output logic [7:0] REC_INDEX,
  input wire logic REC_DONE,
  input wire logic REC_IO_FAULT
);
  import sdi_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'b0000, ST_SRST = 4'b0001, ST_PROBE = 4'b0010, ST_REC = 4'b0011,
    ST_RECW = 4'b0100, ST_RESP = 4'b0101, ST_BYTES = 4'b0110, ST_CFGCHK = 4'b0111
  } sdi_dev_state_t;

  typedef struct packed
  {
    sdi_dev_state_t state;
    logic auto_cfg, is_probe, discovered, found, inited;
    sdi_result_t status;
    logic [7:0] addr, rev;
    logic [15:0] model;
    logic [1:0] byte_idx;
    logic [7:0] cnt, rec_idx;
    logic cmd_ready, rsp_valid;
    sdi_result_t rsp_status;
    logic rsp_byte_valid;
    logic [7:0] rsp_byte;
    logic sns_reset, prb_start, rec_apply, cfg_done, cfg_ok;
  } sdi_dev_t;

  sdi_dev_t r;
  sdi_dev_t next_r;

  function automatic logic [7:0] resp_byte(input sdi_dev_t s, input logic [1:0] idx);
    logic [7:0] b;
    b = s.addr;
    unique case (idx)
      `SDI_OFS_ADDR: b = s.addr;
      `SDI_OFS_REV: b = s.rev;
      `SDI_OFS_MODEL_HI: b = s.model[15:8];
      `SDI_OFS_MODEL_LO: b = s.model[7:0];
    endcase
    return b;
  endfunction

  logic quiescent;
  assign quiescent = (SYS_STATE == SYS_IDLE) || (SYS_STATE == SYS_SUSPENDED);

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_r = r;
    next_r.cmd_ready = 1'b0;
    next_r.rsp_valid = 1'b0;
    next_r.rsp_byte_valid = 1'b0;
    next_r.prb_start = 1'b0;
    next_r.rec_apply = 1'b0;
    next_r.cfg_done = 1'b0;
    unique case (r.state)
      ST_IDLE:
      begin
        next_r.cnt = 8'h00;
        next_r.rec_idx = 8'h00;
        if (LINK.cmd_valid)
        begin
          next_r.cmd_ready = 1'b1;
          next_r.auto_cfg = 1'b0;
          next_r.is_probe = (LINK.cmd_code == `SDI_CMD_PROBE);
          next_r.state = ST_RESP;
          if (LINK.cmd_code != `SDI_CMD_PROBE && LINK.cmd_code != `SDI_CMD_SETUP)
            next_r.status = RESULT_BAD_COMMAND;
          else if (LINK.serial_bus_manager_lock)
            next_r.status = RESULT_LOCK_BUSY; // [R9]
          else if (!quiescent)
            next_r.status = RESULT_STATE_DENIED; // [R10] [R11]
          else if (LINK.cmd_code == `SDI_CMD_PROBE) // [R1]
          begin
            if (r.discovered)
              next_r.status = RESULT_ALREADY_DONE; // [R12]
            else
              next_r.state = ST_SRST;
          end
          else if (r.inited) // [R2] [R17]
            next_r.status = RESULT_ALREADY_DONE; // [R13]
          else if (!r.discovered || !r.found)
            next_r.status = RESULT_NOT_FOUND; // [R15]
          else if (!SNS_SUPPORTED)
            next_r.status = RESULT_UNSUPPORTED_IMAGER; // [R16]
          else
            next_r.state = ST_REC;
        end
        else if (CFG_REQ)
        begin
          // Config change probes if not yet probed, and sets up a found, supported imager that is not yet set up
          next_r.auto_cfg = 1'b1; // [R3]
          next_r.is_probe = 1'b0;
          next_r.state = r.discovered ? ST_CFGCHK : ST_SRST;
        end
      end
      ST_SRST:
      begin
        // Imager held in reset before the probe starts
        if (r.cnt < `SDI_SNS_RESET_CYC)
        begin
          next_r.sns_reset = 1'b1; // [R8]
          next_r.cnt = r.cnt + 8'h01;
        end
        else
        begin
          next_r.sns_reset = 1'b0;
          next_r.prb_start = 1'b1;
          next_r.state = ST_PROBE;
        end
      end
      ST_PROBE:
      begin
        if (PRB_DONE)
        begin
          next_r.discovered = 1'b1; // [R12]
          next_r.state = r.auto_cfg ? ST_CFGCHK : ST_RESP;
          unique case (PRB_RESULT)
            PROBE_FOUND:
            begin
              next_r.found = 1'b1;
              next_r.addr = PRB_ADDR;
              next_r.rev = PRB_REV;
              next_r.model = PRB_MODEL;
              next_r.status = RESULT_SUCCESS; // [R7]
            end
            PROBE_IO_FAULT: next_r.status = RESULT_IO_FAULT; // [R7]
            default: next_r.status = RESULT_NOT_FOUND; // [R7]
          endcase
        end
      end
      ST_CFGCHK:
      begin
        next_r.state = ST_IDLE;
        next_r.cfg_done = 1'b1;
        next_r.cfg_ok = r.found && r.inited; // [R4]
        if (r.found && !r.inited && SNS_SUPPORTED)
        begin
          next_r.cfg_done = 1'b0;
          next_r.state = ST_REC;
        end
      end
      ST_REC:
      begin
        if (r.rec_idx == REC_COUNT)
        begin
          next_r.inited = 1'b1; // [R13]
          next_r.status = RESULT_SUCCESS;
          next_r.state = ST_RESP;
        end
        else
        begin
          next_r.rec_apply = 1'b1; // [R14]
          next_r.state = ST_RECW;
        end
      end
      ST_RECW:
      begin
        if (REC_DONE && REC_IO_FAULT)
        begin
          next_r.status = RESULT_IO_FAULT;
          next_r.state = ST_RESP;
        end
        else if (REC_DONE)
        begin
          next_r.rec_idx = r.rec_idx + 8'h01; // [R14]
          next_r.state = ST_REC;
        end
      end
      ST_RESP:
      begin
        // Config-driven setup ends on the config strobe, never on the link
        next_r.byte_idx = 2'h0;
        next_r.state = ST_IDLE;
        if (r.auto_cfg)
        begin
          next_r.cfg_done = 1'b1;
          next_r.cfg_ok = (r.status == RESULT_SUCCESS); // [R3]
        end
        else
        begin
          next_r.rsp_valid = 1'b1; // [R19]
          next_r.rsp_status = r.status;
          if (r.status == RESULT_SUCCESS && r.is_probe)
            next_r.state = ST_BYTES; // [R6] [R19]
        end
      end
      ST_BYTES:
      begin
        // Model goes out high byte first
        next_r.rsp_byte_valid = 1'b1;
        next_r.rsp_byte = resp_byte(r, r.byte_idx); // [R6] [R18]
        next_r.byte_idx = r.byte_idx + 2'h1;
        if (r.byte_idx == `SDI_OFS_MODEL_LO)
          next_r.state = ST_IDLE;
      end
      default: next_r.state = ST_IDLE;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLK)
  begin
    // Idle state and success code are both all zeros
    if (RST)
      r <= '0;
    else
      r <= next_r;
  end

  assign LINK.cmd_ready = r.cmd_ready;
  assign LINK.rsp_valid = r.rsp_valid;
  assign LINK.rsp_status = r.rsp_status;
  assign LINK.rsp_byte_valid = r.rsp_byte_valid;
  assign LINK.rsp_byte = r.rsp_byte;
  assign CFG_DONE = r.cfg_done;
  assign CFG_OK = r.cfg_ok;
  assign SNS_RESET = r.sns_reset;
  assign PRB_START = r.prb_start;
  assign REC_APPLY = r.rec_apply;
  assign REC_INDEX = r.rec_idx;
endmodule

// ### hdl/sdi_host.sv
`timescale 1ns/1ps
`include "sdi_defs.svh"

module sdi_host
  import sdi_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  sdi_if.host LINK,
  input wire logic USR_START,
  input wire logic USR_SETUP,
  input wire logic USR_LOCK,
  output logic USR_BUSY,
  output logic USR_DONE,
  output logic [7:0] USR_STATUS,
  output logic [7:0] USR_ADDR,
  output logic [7:0] USR_REV,
  output logic [15:0] USR_MODEL
);
  import sdi_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0]
  {
    HS_IDLE = 2'b00,
    HS_REQ = 2'b01,
    HS_WAIT = 2'b10,
    HS_BYTES = 2'b11
  } sdi_host_state_t;

  typedef struct packed
  {
    sdi_host_state_t state;
    logic setup;
    logic [1:0] byte_idx;
    logic cmd_valid;
    logic [15:0] cmd_code;
    logic lock;
    logic busy;
    logic done;
    logic [7:0] status;
    logic [7:0] addr;
    logic [7:0] rev;
    logic [15:0] model;
  } sdi_host_t;

  sdi_host_t r;
  sdi_host_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.lock = USR_LOCK;
    unique case (r.state)
      HS_IDLE:
      begin
        if (USR_START)
        begin
          next_r.setup = USR_SETUP;
          next_r.cmd_valid = 1'b1;
          next_r.cmd_code = USR_SETUP ? `SDI_CMD_SETUP : `SDI_CMD_PROBE;
          next_r.busy = 1'b1;
          next_r.state = HS_REQ;
        end
      end
      HS_REQ:
      begin
        if (LINK.cmd_ready)
        begin
          next_r.cmd_valid = 1'b0;
          next_r.state = HS_WAIT;
        end
      end
      HS_WAIT:
      begin
        if (LINK.rsp_valid)
        begin
          next_r.status = LINK.rsp_status;
          next_r.byte_idx = 2'h0;
          if (LINK.rsp_status == `SDI_RES_SUCCESS && !r.setup)
            next_r.state = HS_BYTES;
          else
          begin
            next_r.done = 1'b1;
            next_r.busy = 1'b0;
            next_r.state = HS_IDLE;
          end
        end
      end
      HS_BYTES:
      begin
        if (LINK.rsp_byte_valid)
        begin
          // Bytes arrive most significant first
          unique case (r.byte_idx)
            `SDI_OFS_ADDR: next_r.addr = LINK.rsp_byte;
            `SDI_OFS_REV: next_r.rev = LINK.rsp_byte;
            `SDI_OFS_MODEL_HI: next_r.model[15:8] = LINK.rsp_byte; // [R18]
            `SDI_OFS_MODEL_LO: next_r.model[7:0] = LINK.rsp_byte; // [R18]
          endcase
          next_r.byte_idx = r.byte_idx + 2'h1;
          if (r.byte_idx == `SDI_OFS_MODEL_LO)
          begin
            next_r.done = 1'b1;
            next_r.busy = 1'b0;
            next_r.state = HS_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      r <= '0;
      r.state <= HS_IDLE;
    end
    else
      r <= next_r;
  end

  assign LINK.cmd_valid = r.cmd_valid;
  assign LINK.cmd_code = r.cmd_code;
  assign LINK.serial_bus_manager_lock = r.lock;
  assign USR_BUSY = r.busy;
  assign USR_DONE = r.done;
  assign USR_STATUS = r.status;
  assign USR_ADDR = r.addr;
  assign USR_REV = r.rev;
  assign USR_MODEL = r.model;
endmodule

// ### verification/sdi_sva.sv
`timescale 1ns/1ps
`include "sdi_defs.svh"

module sdi_sva
  import sdi_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_code,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_status,
  input wire logic rsp_byte_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic serial_bus_manager_lock
);
  // ********
  // Helper state
  // ********
  logic [15:0] last_code;
  logic pending;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      last_code <= 16'h0000;
      pending <= 1'b0;
    end
    else if (cmd_ready)
    begin
      last_code <= cmd_code;
      pending <= 1'b1;
    end
    else if (rsp_valid)
    begin
      pending <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // ********
  // Link checks
  // ********
  AST_READY_TAKEN: assert property (cmd_ready |-> cmd_valid && $past(cmd_valid))
    else $error("cmd_ready without a held request");
  AST_READY_IDLE: assert property (cmd_ready |-> !pending && !rsp_byte_valid)
    else $error("command taken while one is outstanding");
  AST_RSP_PENDING: assert property (rsp_valid |-> pending && !cmd_ready)
    else $error("result without an outstanding command");
  AST_LOCK_BUSY: assert property (cmd_ready && $past(serial_bus_manager_lock) &&
    (cmd_code == `SDI_CMD_PROBE || cmd_code == `SDI_CMD_SETUP) |=>
    rsp_valid && rsp_status == RESULT_LOCK_BUSY)
    else $error("lock held but result is not busy");
  AST_FAIL_NO_BYTES: assert property (rsp_valid && rsp_status != RESULT_SUCCESS |=>
    !rsp_byte_valid [*5])
    else $error("response bytes after a failed command");
  AST_PROBE_BYTES: assert property (rsp_valid && rsp_status == RESULT_SUCCESS &&
    last_code == `SDI_CMD_PROBE |=> rsp_byte_valid [*4] ##1 !rsp_byte_valid)
    else $error("probe success not followed by four bytes");
  AST_SETUP_NO_BYTES: assert property (rsp_valid && last_code == `SDI_CMD_SETUP |=>
    !rsp_byte_valid [*2])
    else $error("response bytes after setup");
  AST_STATUS_HOLD: assert property (rsp_valid |=> $stable(rsp_status) [*2])
    else $error("result code changed without a new result");

  COV_PROBE_OK: cover property (rsp_valid && rsp_status == RESULT_SUCCESS &&
    last_code == `SDI_CMD_PROBE);
  COV_SETUP_OK: cover property (rsp_valid && rsp_status == RESULT_SUCCESS &&
    last_code == `SDI_CMD_SETUP);
  COV_BUSY: cover property (rsp_valid && rsp_status == RESULT_LOCK_BUSY);
endmodule

// ### verification/sdi_tb.sv
`timescale 1ns/1ps

module sdi_tb;
  import sdi_pkg::*;
  typedef struct {logic s; logic lk; sdi_sys_state_t st; logic sup; logic flt;
    logic [7:0] ex; logic [7:0] nrec;} sdi_row_t;
  localparam logic [7:0] ADDR = 8'h48;
  localparam logic [7:0] REV = 8'h03;
  localparam logic [15:0] MODEL = 16'hA51C;
  logic CLK, RST, cfg_req, cfg_done, cfg_ok, sns_reset, prb_start, sns_supported;
  logic rec_apply, rec_flt, usr_start, usr_setup, usr_lock, usr_busy, usr_done;
  logic prb_done = 1'b0, rec_done = 1'b0, rec_io_fault = 1'b0;
  logic [7:0] rec_n = 8'h00, rst_cyc = 8'h00;
  logic [7:0] rec_index, rec_base, rec_cnt, usr_status, usr_addr, usr_rev;
  logic [15:0] usr_model;
  logic [7:0] bq[$];
  sdi_sys_state_t sys_state;
  sdi_probe_t prb_result;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  // Ordinary cases; order matters, the once-per-reset flags carry over
  sdi_row_t rows [11] = '{
    '{0, 1, SYS_IDLE, 1, 0, RESULT_LOCK_BUSY, 8'h00},
    '{1, 1, SYS_IDLE, 1, 0, RESULT_LOCK_BUSY, 8'h00},
    '{0, 0, SYS_STREAMING, 1, 0, RESULT_STATE_DENIED, 8'h00},
    '{1, 0, SYS_OTHER, 1, 0, RESULT_STATE_DENIED, 8'h00},
    '{1, 0, SYS_IDLE, 1, 0, RESULT_NOT_FOUND, 8'h00},
    '{0, 0, SYS_SUSPENDED, 1, 0, RESULT_SUCCESS, 8'h00},
    '{0, 0, SYS_IDLE, 1, 0, RESULT_ALREADY_DONE, 8'h00},
    '{1, 0, SYS_IDLE, 0, 0, RESULT_UNSUPPORTED_IMAGER, 8'h00},
    '{1, 0, SYS_SUSPENDED, 1, 1, RESULT_IO_FAULT, 8'h01},
    '{1, 0, SYS_IDLE, 1, 0, RESULT_SUCCESS, 8'h03},
    '{1, 0, SYS_IDLE, 1, 0, RESULT_ALREADY_DONE, 8'h00}};

  sdi_if lnk();

  sdi_device sdi_device_i (.CLK(CLK), .RST(RST), .LINK(lnk), .SYS_STATE(sys_state),
    .CFG_REQ(cfg_req), .CFG_DONE(cfg_done), .CFG_OK(cfg_ok), .SNS_RESET(sns_reset),
    .PRB_START(prb_start), .PRB_DONE(prb_done), .PRB_RESULT(prb_result), .PRB_ADDR(ADDR),
    .PRB_REV(REV), .PRB_MODEL(MODEL), .SNS_SUPPORTED(sns_supported), .REC_COUNT(rec_cnt),
    .REC_APPLY(rec_apply), .REC_INDEX(rec_index), .REC_DONE(rec_done),
    .REC_IO_FAULT(rec_io_fault));

  sdi_host sdi_host_i (.CLK(CLK), .RST(RST), .LINK(lnk), .USR_START(usr_start),
    .USR_SETUP(usr_setup), .USR_LOCK(usr_lock), .USR_BUSY(usr_busy), .USR_DONE(usr_done),
    .USR_STATUS(usr_status), .USR_ADDR(usr_addr), .USR_REV(usr_rev), .USR_MODEL(usr_model));

  sdi_sva sdi_sva_i (.CLK(CLK), .RST(RST), .cmd_valid(lnk.cmd_valid),
    .cmd_code(lnk.cmd_code), .cmd_ready(lnk.cmd_ready), .rsp_valid(lnk.rsp_valid),
    .rsp_status(lnk.rsp_status), .rsp_byte_valid(lnk.rsp_byte_valid),
    .rsp_byte(lnk.rsp_byte), .serial_bus_manager_lock(lnk.serial_bus_manager_lock));

  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // ********
  // Imager and record store stand-in, byte monitor, hang guard
  // ********
  always @(posedge CLK)
  begin
    prb_done <= 1'b0;
    rec_done <= 1'b0;
    cyc <= cyc + 1;
    if (lnk.rsp_byte_valid === 1'b1)
    begin
      bq.push_back(lnk.rsp_byte);
    end
    if (RST)
    begin
      rst_cyc <= 8'h00;
    end
    else if (sns_reset === 1'b1)
    begin
      rst_cyc <= rst_cyc + 8'h01;
    end
    if (prb_start === 1'b1)
    begin
      chk("imager reset cycles", {8'h00, rst_cyc}, 16'h0004);
      rst_cyc <= 8'h00;
      prb_done <= 1'b1;
    end
    if (rec_apply === 1'b1)
    begin
      chk("record index", {8'h00, rec_index}, {8'h00, rec_n - rec_base});
      rec_n <= rec_n + 8'h01;
      rec_done <= 1'b1;
      rec_io_fault <= rec_flt;
    end
    if (cyc == 8000)
    begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge CLK);
    RST <= 1'b1;
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
  endtask

  // Lock goes through a register in the host, so it is set well before the start
  task automatic run(input logic s, input logic lk, input logic [7:0] ex,
    input logic [7:0] nrec);
    int n;
    n = 0;
    @(posedge CLK);
    usr_lock <= lk;
    repeat (3) @(posedge CLK);
    bq.delete();
    rec_base = rec_n;
    usr_setup <= s;
    usr_start <= 1'b1;
    @(posedge CLK);
    usr_start <= 1'b0;
    @(negedge CLK);
    chk("host busy", {15'h0000, usr_busy}, 16'h0001);
    do @(negedge CLK); while (usr_done !== 1'b1 && ++n < 400);
    chk("host done and busy", {14'h0000, usr_done, usr_busy}, 16'h0002);
    chk("result code", {8'h00, usr_status}, {8'h00, ex});
    if (nrec !== 8'hFF)
    begin
      chk("records applied", {8'h00, rec_n - rec_base}, {8'h00, nrec});
    end
    if (ex === RESULT_SUCCESS && !s)
    begin
      chk("link bytes 0 1", {bq[0], bq[1]}, {ADDR, REV});
      chk("link bytes 2 3", {bq[2], bq[3]}, MODEL);
      chk("host fields", {usr_addr, usr_rev}, {ADDR, REV});
      chk("host model", usr_model, MODEL);
    end
    else
    begin
      chk("byte count", 16'(bq.size()), 16'h0000);
    end
  endtask

  task automatic cfg(input logic ok, input logic [7:0] nrec);
    int n;
    n = 0;
    rec_base = rec_n;
    @(posedge CLK);
    cfg_req <= 1'b1;
    @(posedge CLK);
    cfg_req <= 1'b0;
    do @(negedge CLK); while (cfg_done !== 1'b1 && ++n < 400);
    chk("config done", {15'h0000, cfg_done}, 16'h0001);
    chk("config ok", {15'h0000, cfg_ok}, {15'h0000, ok});
    chk("config records", {8'h00, rec_n - rec_base}, {8'h00, nrec});
  endtask

  initial
  begin
    RST = 1'b1;
    sys_state = SYS_IDLE;
    prb_result = PROBE_FOUND;
    {cfg_req, rec_flt} = 2'h0;
    {usr_start, usr_setup, usr_lock, sns_supported} = 4'h1;
    {rec_base, rec_cnt} = 16'h0003;
    do_reset();
    foreach (rows[i])
    begin
      @(posedge CLK);
      sys_state <= rows[i].st;
      sns_supported <= rows[i].sup;
      rec_flt <= rows[i].flt;
      run(rows[i].s, rows[i].lk, rows[i].ex, rows[i].nrec);
    end
    do_reset();
    prb_result <= PROBE_IO_FAULT;
    run(1'b0, 1'b0, RESULT_IO_FAULT, 8'h00);
    run(1'b0, 1'b0, RESULT_ALREADY_DONE, 8'h00);
    do_reset();
    prb_result <= PROBE_NONE;
    run(1'b0, 1'b0, RESULT_NOT_FOUND, 8'h00);
    run(1'b1, 1'b0, RESULT_NOT_FOUND, 8'h00);
    do_reset();
    prb_result <= PROBE_FOUND;
    rec_cnt <= 8'h00;
    run(1'b0, 1'b0, RESULT_SUCCESS, 8'h00);
    run(1'b1, 1'b0, RESULT_SUCCESS, 8'h00);
    do_reset();
    rec_cnt <= 8'h03;
    sns_supported <= 1'b0;
    cfg(1'b0, 8'h00);
    do_reset();
    sns_supported <= 1'b1;
    cfg(1'b1, 8'h03);
    run(1'b1, 1'b0, RESULT_ALREADY_DONE, 8'h00);
    close_out();
  end
endmodule
